// [design/nsc_pkg.sv]
/*
 * nsc_pkg: register map, field positions, reset values and shared types for
 * the navigation sensor configuration block.
 * Assumes one 100 MHz core clock; the serial port clock is sampled, not used.
 */
`default_nettype none

package nsc_pkg;
	// register offsets
	localparam logic [6:0] ADDR_SENSOR_CONFIGURATION = 7'h11;
	localparam logic [6:0] ADDR_FRAME_MONITOR        = 7'h2e;
	localparam logic [6:0] ADDR_SOFT_RESET_KEY       = 7'h3a;
	localparam logic [6:0] ADDR_INVERTED_REVISION    = 7'h3e;
	localparam logic [6:0] ADDR_INVERTED_PRODUCT     = 7'h3f;
	localparam logic [6:0] ADDR_BURST_READ_PORT      = 7'h42;

	// field positions and values
	localparam int         CFG_RES_BIT        = 7;
	localparam int         CFG_SLEEP_LSB      = 4;
	localparam int         MON_MODE_LSB       = 6;
	localparam logic [7:0] CFG_RESET          = 8'h03;
	localparam logic [7:0] CFG_WRITE_MASK     = 8'hb0;
	localparam logic [7:0] SOFT_RESET_VALUE   = 8'h5a;
	localparam logic [3:0] ALIVE_ALL          = 4'hf;
	localparam logic [2:0] BURST_CLEAR_COUNT  = 3'h3;
	localparam logic [2:0] BURST_LAST_INDEX   = 3'h6;

	// serial address byte: msb set marks a write
	localparam int         ADDR_WRITE_BIT     = 7;

	// identity codes, values arbitrary
	localparam logic [7:0] REVISION_CODE      = 8'h15;
	localparam logic [7:0] PART_CODE          = 8'h2c;

	// snapshot of navigation results streamed by a burst read
	typedef struct packed {
		logic [7:0] motionStatus;
		logic [7:0] deltaY;
		logic [7:0] deltaX;
		logic [7:0] surfaceQuality;
		logic [7:0] exposureUpper;
		logic [7:0] exposureLower;
		logic [7:0] peakPixel;
	} nsc_nav_t;

	// settings driven into the navigation core
	typedef struct packed {
		logic       highRes;          // 0: 500 cpi, 1: 1000 cpi
		logic [1:0] forcedSleepSelect;
	} nsc_cfg_t;

	// the three input pins of the four-wire serial port (miso is separate), device view
	typedef struct packed {
		logic csN;
		logic sclk;
		logic mosi;
	} nsc_pins_t;
endpackage : nsc_pkg

`default_nettype wire

// [design/nsc_serial_port.sv]
/*
 * nsc_serial_port: serial port slave shifter for the sensor.
 * Assumes the host drives mosi on the falling sclk edge and samples miso on
 * the rising one, sclk idles high, and the port pins are asynchronous to mclk.
 */
`default_nettype none

module nsc_serial_port (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire nsc_pkg::nsc_pins_t pins,
	input  wire logic [7:0]        txByte,
	input  wire logic              txLoad,
	output logic [7:0]             rxByte,
	output logic                   rxValid,
	output logic                   frameStart,
	output logic                   misoOut,
	output logic                   misoOe
);
	logic [2:0] stage1;
	logic [2:0] stage2;
	logic [2:0] stage3;
	logic [2:0] filt_r;
	logic [2:0] filtPrev_r;
	logic [2:0] bitCnt_r;
	logic [7:0] rxShift_r;
	logic [7:0] txShift_r;
	logic       csN;
	logic       sclkRise;
	logic       sclkFall;

	// three flops per pin; a level is accepted once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (rst) begin
					stage1[gi] <= 1'b1;
					stage2[gi] <= 1'b1;
					stage3[gi] <= 1'b1;
					filt_r[gi] <= 1'b1;
					filtPrev_r[gi] <= 1'b1;
				end else begin
					stage1[gi] <= pins[gi];
					stage2[gi] <= stage1[gi];
					stage3[gi] <= stage2[gi];
					if (stage2[gi] == stage3[gi]) begin
						filt_r[gi] <= stage3[gi];
					end
					filtPrev_r[gi] <= filt_r[gi];
				end
			end
		end
	endgenerate

	// bit order of the packed pin struct: 2 csN, 1 sclk, 0 mosi
	assign csN      = filt_r[2];
	assign sclkRise = !csN && filt_r[1] && !filtPrev_r[1];
	assign sclkFall = !csN && !filt_r[1] && filtPrev_r[1];

	// receive side: capture mosi on rising edges, msb first
	always_ff @(posedge mclk) begin
		if (rst || csN) begin
			bitCnt_r  <= 3'h0;
			rxShift_r <= 8'h00;
			rxValid   <= 1'b0;
			rxByte    <= 8'h00;
		end else begin
			rxValid <= 1'b0;
			if (sclkRise) begin
				rxShift_r <= {rxShift_r[6:0], filt_r[0]};
				bitCnt_r  <= bitCnt_r + 3'h1;
				if (bitCnt_r == 3'h7) begin
					rxByte  <= {rxShift_r[6:0], filt_r[0]};
					rxValid <= 1'b1;
				end
			end
		end
	end

	// frame start pulse on the falling edge of chip select
	always_ff @(posedge mclk) begin
		if (rst) begin
			frameStart <= 1'b0;
		end else begin
			frameStart <= !filt_r[2] && filtPrev_r[2];
		end
	end

	// transmit side: present next bit on each falling edge; a load lands
	// between the eighth rising edge and the next falling one
	always_ff @(posedge mclk) begin
		if (rst || csN) begin
			txShift_r <= 8'h00;
			misoOut   <= 1'b0;
		end else if (txLoad) begin
			txShift_r <= txByte;
		end else if (sclkFall) begin
			misoOut   <= txShift_r[7];
			txShift_r <= {txShift_r[6:0], 1'b0};
		end
	end

	// miso is driven only while selected
	always_ff @(posedge mclk) begin
		if (rst) begin
			misoOe <= 1'b0;
		end else begin
			misoOe <= !csN;
		end
	end
endmodule // nsc_serial_port

`default_nettype wire

// [design/nsc_config_regs.sv]
/*
 * nsc_config_regs: configuration and status registers of the navigation
 * sensor reached over the four-wire serial port, with motion burst read.
 * Assumes navigation results, sleep state and frame pulses come from logic
 * on mclk; the serial pins are asynchronous and synchronised in the port.
 */
`default_nettype none

module nsc_config_regs (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire nsc_pkg::nsc_pins_t portPins,
	input  wire nsc_pkg::nsc_nav_t  navData,
	input  wire logic [1:0]         sleepState,
	input  wire logic               frameDone,
	output logic                    misoOut,
	output logic                    misoOe,
	output nsc_pkg::nsc_cfg_t       cfgOut,
	output logic                    motionClear,
	output logic                    chipReset
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WRITE,
		ST_READ,
		ST_BURST,
		ST_DONE
	} nsc_state_t;

	nsc_state_t        state_r;
	nsc_state_t        state_nxt;
	logic [7:0]        rxByte;
	logic              rxValid;
	logic              frameStart;
	logic [6:0]        addr_r;
	logic [7:0]        cfgReg_r;
	logic [3:0]        aliveBits_r;
	logic [2:0]        burstIdx_r;
	logic              burstCleared_r;
	nsc_pkg::nsc_nav_t snap_r;
	logic [7:0]        txByte_r;
	logic              txLoad_r;
	logic              softReset_r;
	logic              regRst;
	logic              wrStrobe;
	logic [7:0]        readData;
	logic [7:0]        burstData;

	nsc_serial_port u_port (
		.mclk       (mclk),
		.rst        (rst),
		.pins       (portPins),
		.txByte     (txByte_r),
		.txLoad     (txLoad_r),
		.rxByte     (rxByte),
		.rxValid    (rxValid),
		.frameStart (frameStart),
		.misoOut    (misoOut),
		.misoOe     (misoOe)
	);

	// key write resets every setting, like a pin reset
	assign regRst   = rst || softReset_r;
	assign wrStrobe = (state_r == ST_WRITE) && rxValid;

	// transaction sequencer: address byte, then write data or read stream
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				state_nxt = ST_IDLE;
			end
			ST_ADDR: begin
				if (rxValid) begin
					if (rxByte[nsc_pkg::ADDR_WRITE_BIT]) begin
						state_nxt = ST_WRITE;
					end else if (rxByte[6:0] == nsc_pkg::ADDR_BURST_READ_PORT) begin
						state_nxt = ST_BURST;
					end else begin
						state_nxt = ST_READ;
					end
				end
			end
			ST_WRITE, ST_READ: begin
				if (rxValid) begin
					state_nxt = ST_DONE;
				end
			end
			ST_BURST: begin
				if (rxValid && burstIdx_r == nsc_pkg::BURST_LAST_INDEX) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_DONE;
			end
		endcase
		if (frameStart) begin
			state_nxt = ST_ADDR;
		end
	end

	always_ff @(posedge mclk) begin
		if (regRst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// captured address of the current transfer
	always_ff @(posedge mclk) begin
		if (regRst) begin
			addr_r <= 7'h00;
		end else if (state_r == ST_ADDR && rxValid) begin
			addr_r <= rxByte[6:0];
		end
	end

	// configuration: only resolution and sleep select are writable
	always_ff @(posedge mclk) begin
		if (regRst) begin
			cfgReg_r <= nsc_pkg::CFG_RESET;
		end else if (wrStrobe && addr_r == nsc_pkg::ADDR_SENSOR_CONFIGURATION) begin
			cfgReg_r <= (rxByte & nsc_pkg::CFG_WRITE_MASK) |
				(nsc_pkg::CFG_RESET & ~nsc_pkg::CFG_WRITE_MASK);
		end
	end

	// settings to the core, registered so the output is flop driven
	always_ff @(posedge mclk) begin
		if (regRst) begin
			cfgOut.highRes           <= nsc_pkg::CFG_RESET[nsc_pkg::CFG_RES_BIT];
			cfgOut.forcedSleepSelect <= nsc_pkg::CFG_RESET[nsc_pkg::CFG_SLEEP_LSB +: 2];
		end else begin
			cfgOut.highRes           <= cfgReg_r[nsc_pkg::CFG_RES_BIT];
			cfgOut.forcedSleepSelect <= cfgReg_r[nsc_pkg::CFG_SLEEP_LSB +: 2];
		end
	end

	// frame alive bits; a frame in the clearing cycle still sets them
	always_ff @(posedge mclk) begin
		if (regRst) begin
			aliveBits_r <= 4'h0;
		end else if (frameDone) begin
			aliveBits_r <= nsc_pkg::ALIVE_ALL;
		end else if (wrStrobe && addr_r == nsc_pkg::ADDR_FRAME_MONITOR) begin
			aliveBits_r <= 4'h0;
		end
	end

	// soft reset key: one-cycle pulse, also reported to the rest of the chip
	always_ff @(posedge mclk) begin
		if (rst) begin
			softReset_r <= 1'b0;
			chipReset   <= 1'b0;
		end else begin
			softReset_r <= wrStrobe && addr_r == nsc_pkg::ADDR_SOFT_RESET_KEY &&
				rxByte == nsc_pkg::SOFT_RESET_VALUE;
			chipReset   <= softReset_r;
		end
	end

	// single register reads; unmapped addresses give zero
	always_comb begin
		readData = 8'h00;
		unique case (rxByte[6:0])
			nsc_pkg::ADDR_SENSOR_CONFIGURATION: readData = cfgReg_r;
			nsc_pkg::ADDR_FRAME_MONITOR: readData = {sleepState, 2'b00, aliveBits_r};
			nsc_pkg::ADDR_INVERTED_REVISION: readData = ~nsc_pkg::REVISION_CODE;
			nsc_pkg::ADDR_INVERTED_PRODUCT: readData = ~nsc_pkg::PART_CODE;
			default: readData = 8'h00;
		endcase
	end

	// burst bytes come from a snapshot so the stream is self-consistent
	always_comb begin
		burstData = 8'h00;
		unique case (burstIdx_r)
			3'h0: burstData = snap_r.deltaY;
			3'h1: burstData = snap_r.deltaX;
			3'h2: burstData = snap_r.surfaceQuality;
			3'h3: burstData = snap_r.exposureUpper;
			3'h4: burstData = snap_r.exposureLower;
			3'h5: burstData = snap_r.peakPixel;
			default: burstData = 8'h00;
		endcase
	end

	// transmit loading: first byte after address, then each completed byte
	always_ff @(posedge mclk) begin
		if (regRst) begin
			txByte_r <= 8'h00;
			txLoad_r <= 1'b0;
			snap_r   <= '0;
		end else begin
			txLoad_r <= 1'b0;
			if (state_r == ST_ADDR && rxValid && !rxByte[nsc_pkg::ADDR_WRITE_BIT]) begin
				txLoad_r <= 1'b1;
				if (rxByte[6:0] == nsc_pkg::ADDR_BURST_READ_PORT) begin
					snap_r   <= navData;
					txByte_r <= navData.motionStatus;
				end else begin
					txByte_r <= readData;
				end
			end else if (state_r == ST_BURST && rxValid) begin
				txLoad_r <= 1'b1;
				txByte_r <= burstData;
			end else if (rxValid) begin
				txLoad_r <= 1'b1;
				txByte_r <= 8'h00;
			end
		end
	end

	// burst progress; motion clears after the third byte is shifted out,
	// so a host that stops early leaves the motion data intact (host keeps three)
	always_ff @(posedge mclk) begin
		if (regRst || frameStart) begin
			burstIdx_r     <= 3'h0;
			burstCleared_r <= 1'b0;
			motionClear    <= 1'b0;
		end else begin
			motionClear <= 1'b0;
			if (state_r == ST_BURST && rxValid) begin
				burstIdx_r <= burstIdx_r + 3'h1;
				if (burstIdx_r + 3'h1 == nsc_pkg::BURST_CLEAR_COUNT && !burstCleared_r) begin
					motionClear    <= 1'b1;
					burstCleared_r <= 1'b1;
				end
			end
		end
	end
endmodule // nsc_config_regs

`default_nettype wire

// [sim/nsc_regs_checker.sv]
/* nsc_regs_checker: port-level assertions for nsc_config_regs.
 * Assumes the single mclk domain and the synchronous active-high rst. */
`default_nettype none
module nsc_regs_checker (
	input wire logic               mclk,
	input wire logic               rst,
	input wire nsc_pkg::nsc_pins_t portPins,
	input wire nsc_pkg::nsc_nav_t  navData,
	input wire logic [1:0]         sleepState,
	input wire logic               frameDone,
	input wire logic               misoOut,
	input wire logic               misoOe,
	input wire nsc_pkg::nsc_cfg_t  cfgOut,
	input wire logic               motionClear,
	input wire logic               chipReset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// select held long enough to pass the pin filters
	sequence s_sel;
		$fell(portPins.csN) ##1 (!portPins.csN)[*7];
	endsequence
	sequence s_idle;
		portPins.csN[*8];
	endsequence
	// reset itself is the cause here, so it must not disable the check
	property p_reset;
		disable iff (1'b0) rst |=> cfgOut == 3'b000 && !motionClear && !chipReset;
	endproperty
	a_reset_quiet: assert property (p_reset)
		else $error("outputs not cleared by reset");
	a_sel_drive: assert property (s_sel |-> misoOe)
		else $error("miso not driven in frame");
	a_idle_quiet: assert property (s_idle |-> !misoOe && !misoOut)
		else $error("miso active while deselected");
	a_cfg_stable: assert property (s_idle |-> $stable(cfgOut))
		else $error("config moved without a transfer");
	a_clear_pulse: assert property (motionClear |=> !motionClear)
		else $error("motion clear too long");
	a_clear_late: assert property ($rose(misoOe) |-> (!motionClear)[*8])
		else $error("motion clear too early");
	a_key_pulse: assert property (chipReset |=> !chipReset)
		else $error("chip reset too long");
	a_key_framed: assert property (chipReset |-> misoOe)
		else $error("chip reset outside a frame");
	a_key_default: assert property (chipReset |-> ##[1:2] cfgOut == 3'b000)
		else $error("config not restored");
endmodule // nsc_regs_checker
bind nsc_config_regs nsc_regs_checker u_nsc_regs_checker (.mclk(mclk), .rst(rst),
	.portPins(portPins), .navData(navData), .sleepState(sleepState),
	.frameDone(frameDone), .misoOut(misoOut), .misoOe(misoOe), .cfgOut(cfgOut),
	.motionClear(motionClear), .chipReset(chipReset));
`default_nettype wire

// [sim/nsc_host.sv]
/* nsc_host: serial port master model standing in for the controller.
 * Assumes mclk from the bench; sclk runs on its own 125 ns timing, falling off mclk edges and rising on them. */
`default_nettype none
module nsc_host (
	input  wire logic          mclk,
	output nsc_pkg::nsc_pins_t pins,
	input  wire logic          misoOut,
	input  wire logic          misoOe
);
	timeunit 1ns;
	timeprecision 100ps;
	// half of the 125 ns link period; the half-ns offset keeps sclk falls and mosi moves off mclk edges, while sclk rises land on them
	localparam real SCLK_HALF = 62.5;
	logic lastBit = 1'b0;
	// idle: deselected, sclk stands high
	initial pins = '{csN: 1'b1, sclk: 1'b1, mosi: 1'b0};
	task automatic open();
		@(negedge mclk) pins.csN <= 1'b0;
		#(SCLK_HALF);
	endtask
	// mosi moves on fall, miso taken on rise; an undriven miso reads flipped
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			pins.sclk <= 1'b0;
			pins.mosi <= tx[i];
			#(SCLK_HALF);
			lastBit = misoOe ? misoOut : ~lastBit;
			rx[i] = lastBit;
			pins.sclk <= 1'b1;
			#(SCLK_HALF);
		end
	endtask
	task automatic close();
		#(SCLK_HALF);
		pins.csN <= 1'b1;
		pins.mosi <= ~pins.mosi; // released line must not look held
		#(2 * SCLK_HALF);
		// hand back on a falling mclk edge so bench stimulus stays aligned
		@(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] junk;
		open();
		xbyte({1'b1, a[6:0]}, junk);
		xbyte(d, junk);
		close();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] junk;
		open();
		xbyte({1'b0, a[6:0]}, junk);
		xbyte(8'h00, d);
		close();
	endtask
endmodule // nsc_host
`default_nettype wire

// [sim/nsc_config_regs_tb_top.sv]
/* nsc_config_regs_tb_top: self-checking bench for nsc_config_regs.
 * Assumes nsc_host as serial master and the bound checker. */
`default_nettype none
module nsc_config_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic               mclk = 1'b0;
	logic               rst = 1'b1;
	nsc_pkg::nsc_pins_t pins;
	nsc_pkg::nsc_nav_t  navData = 56'h11223344556677;
	logic [1:0]         sleepState = 2'h0;
	logic               frameDone = 1'b0;
	logic               misoOut, misoOe, motionClear, chipReset;
	nsc_pkg::nsc_cfg_t  cfgOut;
	int                 bad_count = 0, checks = 0, clears = 0, resets = 0;
	logic [7:0]         rdv;
	initial forever #5 mclk = ~mclk;
	// count the one-cycle pulses mid-cycle, away from the launching edge
	always @(negedge mclk) begin
		if (motionClear === 1'b1) clears++;
		if (chipReset === 1'b1) resets++;
	end
	nsc_config_regs u_nsc_config_regs (.mclk(mclk), .rst(rst), .portPins(pins),
		.navData(navData), .sleepState(sleepState), .frameDone(frameDone),
		.misoOut(misoOut), .misoOe(misoOe), .cfgOut(cfgOut),
		.motionClear(motionClear), .chipReset(chipReset));
	nsc_host u_nsc_host (.mclk(mclk), .pins(pins), .misoOut(misoOut), .misoOe(misoOe));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// every sleep code, both resolutions, reserved bits set
	task automatic test_config();
		logic [7:0] vals [4] = '{8'h4c, 8'h90, 8'h2f, 8'hf0};
		check({5'h00, cfgOut}, 8'h00);
		u_nsc_host.rd(8'h11, rdv);
		check(rdv, 8'h03);
		foreach (vals[i]) begin
			u_nsc_host.wr(8'h11, vals[i]);
			check({5'h00, cfgOut}, {5'h00, vals[i][7], vals[i][5:4]});
			u_nsc_host.rd(8'h11, rdv);
			check(rdv, (vals[i] & 8'hb0) | 8'h03);
		end
	endtask
	task automatic test_monitor();
		for (int s = 0; s < 4; s++) begin
			@(negedge mclk) sleepState <= s[1:0];
			frameDone <= 1'b1;
			@(negedge mclk) frameDone <= 1'b0;
			u_nsc_host.rd(8'h2e, rdv);
			check(rdv, {s[1:0], 6'h0f});
			u_nsc_host.wr(8'h2e, {s[1:0], 6'h2a});
			u_nsc_host.rd(8'h2e, rdv);
			check(rdv, {s[1:0], 6'h00});
		end
	endtask
	task automatic test_ident();
		u_nsc_host.wr(8'h3e, 8'h00);
		u_nsc_host.rd(8'h3e, rdv);
		check(rdv, ~nsc_pkg::REVISION_CODE);
		u_nsc_host.rd(8'h3f, rdv);
		check(rdv, ~nsc_pkg::PART_CODE);
		u_nsc_host.wr(8'h20, 8'hff);
		u_nsc_host.rd(8'h20, rdv);
		check(rdv, 8'h00);
	endtask
	// eight bytes: seven results then one past the end
	task automatic test_burst();
		logic [7:0] b;
		u_nsc_host.open();
		u_nsc_host.xbyte(8'h42, b);
		for (int k = 0; k < 8; k++) begin
			u_nsc_host.xbyte(8'h00, b);
			check(b, k < 7 ? navData[55 - 8 * k -: 8] : 8'h00);
			if (k == 1) check(8'(clears), 8'h00);
		end
		u_nsc_host.close();
		check(8'(clears), 8'h01);
	endtask
	task automatic test_key();
		u_nsc_host.wr(8'h11, 8'h90);
		u_nsc_host.wr(8'h3a, 8'h5b);
		check(8'(resets), 8'h00);
		u_nsc_host.wr(8'h3a, nsc_pkg::SOFT_RESET_VALUE);
		check(8'(resets), 8'h01);
		check({5'h00, cfgOut}, 8'h00);
		u_nsc_host.rd(8'h11, rdv);
		check(rdv, 8'h03);
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		rst <= 1'b0;
		repeat (5) @(negedge mclk);
		test_config();
		test_monitor();
		test_ident();
		test_burst();
		test_key();
		give_verdict();
	end
	// watchdog, about two and a half times the expected run
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		give_verdict();
	end
endmodule // nsc_config_regs_tb_top
`default_nettype wire
